/* File: src/pcm_port_c_mux.sv */
/*
 * Port C upper pin multiplexer with latch, direction and control
 * registers, plus remapping of capture/compare channel two.
 * Assumes a one-cycle register port and synchronous peripherals.
 */
// Function
// [RL1] spi master clock drives pin 3
// [RL2] spi slave clock from pin 3
// [RL3] i2c clock in, threshold selectable
// [RL4] i2c data output drives pin 4
// [RL5] i2c data in, threshold selectable
// [RL6] spi data input from pin 4
// [RL7] spi data out drives pin 5
// [RL8] async transmit drives pin 6
// [RL9] sync master clock drives pin 6
// [RL10] sync slave clock from pin 6
// [RL11] async receive from pin 7
// [RL12] sync transmit data drives pin 7
// [RL13] sync receive data from pin 7
// [RL14] peripheral overrides direction bit; spi clock, spi data out and ccp drive only while their dir bit is zero
// [RL15] channel two pin chosen by select
// [RL16] output latch byte read and write
// [RL17] port register reads pin levels
// [RL18] one direction bit per pin
// [RL19] direction one input, zero output
// [RL20] direction reads stored value always
// [RL21] all pins input after reset
// [RL22] fixed priority among peripherals
// [RL23] port write updates output latch
`include "pcm_regs.svh"

module pcm_port_c_mux #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [`PCM_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_pin,
    output logic [WIDTH-1:0] o_pin_oe,
    input wire logic i_ccp_two_pin_select,
    input wire pcm_pkg::pcm_ssp_out_t i_ssp,
    output pcm_pkg::pcm_ssp_in_t o_ssp,
    input wire pcm_pkg::pcm_usart_out_t i_usart,
    output pcm_pkg::pcm_usart_in_t o_usart,
    input wire pcm_pkg::pcm_ccp_out_t i_ccp,
    output logic o_ccp_in,
    output logic o_ccp_alt_out,
    output logic o_ccp_alt_oe
);

    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        pcm_pkg::pcm_ssp_in_t ssp_in;
        pcm_pkg::pcm_usart_in_t usart_in;
        logic ccp_in;
    } pcm_state_t;

    pcm_state_t state_q;
    pcm_state_t state_d;

    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] pin_buf;
    logic [WIDTH-1:0] smbus_sel;
    pcm_pkg::pcm_pin_drive_t drv;
    pcm_pkg::pcm_src_t src6;
    pcm_pkg::pcm_src_t src7;
    logic ssp_en;
    logic ssp_i2c;
    logic us_en;
    logic us_sync;
    logic us_master;
    logic us_txen;
    logic spi_on;
    logic i2c_on;
    logic ccp_here;

    // ==========================================
    // input stages
    pcm_pin_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_pin),
        .o_sync(pin_sync)
    );

    always_comb begin
        smbus_sel = '0;
        smbus_sel[`PCM_PIN_SCK] = i2c_on & state_q.ctrl[`PCM_CTRL_SMBUS];
        smbus_sel[`PCM_PIN_SDA] = i2c_on & state_q.ctrl[`PCM_CTRL_SMBUS];
    end

    pcm_input_buf #(
        .WIDTH(WIDTH)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_level(pin_sync),
        .i_smbus(smbus_sel),
        .o_level(pin_buf)
    );

    // ==========================================
    // mode decode
    assign ssp_en = state_q.ctrl[`PCM_CTRL_SYNC_EN];
    assign ssp_i2c = state_q.ctrl[`PCM_CTRL_SYNC_I2C];
    assign us_en = state_q.ctrl[`PCM_CTRL_USART_EN];
    assign us_sync = state_q.ctrl[`PCM_CTRL_USART_SYNC];
    assign us_master = state_q.ctrl[`PCM_CTRL_USART_MASTER];
    assign us_txen = state_q.ctrl[`PCM_CTRL_USART_TXEN];
    assign spi_on = ssp_en & ~ssp_i2c;
    assign i2c_on = ssp_en & ssp_i2c;
    assign ccp_here = i_ccp_two_pin_select;

    // usart owns pins 6 and 7 only; no pin is shared by two peripherals
    always_comb begin
        src6 = pcm_pkg::PCM_SRC_PORT;
        src7 = pcm_pkg::PCM_SRC_PORT;
        if (us_en) begin
            src6 = pcm_pkg::PCM_SRC_USART; // RL22
            src7 = pcm_pkg::PCM_SRC_USART; // RL22
        end
    end

    // ==========================================
    // output drive per pin
    always_comb begin
        drv.out = state_q.latch;
        drv.oe = ~state_q.dir; // RL19
        if (ccp_here && i_ccp.out_en && !state_q.dir[`PCM_PIN_CCP]) begin
            drv.out[`PCM_PIN_CCP] = i_ccp.out; // RL15
        end
        if (spi_on) begin
            if (!state_q.dir[`PCM_PIN_SCK] && i_ssp.spi_master) begin
                drv.out[`PCM_PIN_SCK] = i_ssp.sck_out; // RL1
            end
            drv.oe[`PCM_PIN_SDA] = 1'b0; // RL6
            if (!state_q.dir[`PCM_PIN_SDO]) begin
                drv.out[`PCM_PIN_SDO] = i_ssp.sdo; // RL7
            end
        end else if (i2c_on) begin
            drv.out[`PCM_PIN_SCK] = i_ssp.scl_out;
            drv.oe[`PCM_PIN_SCK] = i_ssp.scl_oe;
            drv.out[`PCM_PIN_SDA] = i_ssp.sda_out; // RL4
            drv.oe[`PCM_PIN_SDA] = i_ssp.sda_oe; // RL14
        end
        unique case (src6)
            pcm_pkg::PCM_SRC_USART: begin
                if (!us_sync) begin
                    drv.out[`PCM_PIN_TX] = i_usart.tx; // RL8
                    drv.oe[`PCM_PIN_TX] = 1'b1; // RL14
                end else if (us_master) begin
                    drv.out[`PCM_PIN_TX] = i_usart.ck_out; // RL9
                    drv.oe[`PCM_PIN_TX] = 1'b1; // RL14
                end else begin
                    drv.oe[`PCM_PIN_TX] = 1'b0; // RL10
                end
            end
            default: begin
            end
        endcase
        unique case (src7)
            pcm_pkg::PCM_SRC_USART: begin
                if (us_sync && us_txen) begin
                    drv.out[`PCM_PIN_RX] = i_usart.dt_out; // RL12
                    drv.oe[`PCM_PIN_RX] = 1'b1; // RL14
                end else begin
                    drv.oe[`PCM_PIN_RX] = 1'b0; // RL11 RL13
                end
            end
            default: begin
            end
        endcase
    end

    // ==========================================
    // registers and peripheral inputs
    always_comb begin
        state_d = state_q;
        state_d.rdata = 8'h00;
        if (i_wr) begin
            unique case (i_addr)
                `PCM_OFF_LEVELS: state_d.latch = i_wdata; // RL23
                `PCM_OFF_LATCH: state_d.latch = i_wdata; // RL16
                `PCM_OFF_DIR: state_d.dir = i_wdata; // RL18
                `PCM_OFF_CTRL: state_d.ctrl = i_wdata;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                `PCM_OFF_LEVELS: state_d.rdata = pin_sync; // RL17
                `PCM_OFF_LATCH: state_d.rdata = state_q.latch; // RL16
                `PCM_OFF_DIR: state_d.rdata = state_q.dir; // RL20
                `PCM_OFF_CTRL: state_d.rdata = state_q.ctrl;
            endcase
        end
        state_d.ssp_in.sck_in = spi_on & pin_buf[`PCM_PIN_SCK]; // RL2
        state_d.ssp_in.scl_in = i2c_on & pin_buf[`PCM_PIN_SCK]; // RL3
        state_d.ssp_in.sdi = spi_on & pin_buf[`PCM_PIN_SDA]; // RL6
        state_d.ssp_in.sda_in = i2c_on & pin_buf[`PCM_PIN_SDA]; // RL5
        state_d.usart_in.ck_in = us_en & us_sync & ~us_master
            & pin_buf[`PCM_PIN_TX]; // RL10
        state_d.usart_in.rx = us_en & ~us_sync & pin_buf[`PCM_PIN_RX]; // RL11
        state_d.usart_in.dt_in = us_en & us_sync & ~us_txen
            & pin_buf[`PCM_PIN_RX]; // RL13
        state_d.ccp_in = ccp_here & pin_buf[`PCM_PIN_CCP]; // RL15
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= '0;
            state_q.dir <= `PCM_DIR_RST; // RL21
            state_q.latch <= `PCM_LATCH_RST;
            state_q.ctrl <= `PCM_CTRL_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================
    // outputs
    assign o_rdata = state_q.rdata;
    assign o_pin = drv.out;
    assign o_pin_oe = drv.oe;
    assign o_ssp = state_q.ssp_in;
    assign o_usart = state_q.usart_in;
    assign o_ccp_in = state_q.ccp_in;
    assign o_ccp_alt_out = i_ccp.out; // RL15
    assign o_ccp_alt_oe = ~ccp_here & i_ccp.out_en; // RL15

endmodule : pcm_port_c_mux

/* File: src/pcm_regs.svh */
/*
 * Register map, reset values and field positions of the port C pin mux.
 * Assumes inclusion by the package and the main module only.
 */
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH

// ==========================================
// register offsets
`define PCM_ADDR_W 2
`define PCM_OFF_LEVELS 2'h0
`define PCM_OFF_LATCH 2'h1
`define PCM_OFF_DIR 2'h2
`define PCM_OFF_CTRL 2'h3

// ==========================================
// reset values
`define PCM_DIR_RST 8'hFF
`define PCM_LATCH_RST 8'h00
`define PCM_CTRL_RST 8'h00

// ==========================================
// control register fields
`define PCM_CTRL_SYNC_EN 0
`define PCM_CTRL_SYNC_I2C 1
`define PCM_CTRL_SMBUS 2
`define PCM_CTRL_USART_EN 3
`define PCM_CTRL_USART_SYNC 4
`define PCM_CTRL_USART_MASTER 5
`define PCM_CTRL_USART_TXEN 6

// ==========================================
// pin positions
`define PCM_PIN_CCP 1
`define PCM_PIN_SCK 3
`define PCM_PIN_SDA 4
`define PCM_PIN_SDO 5
`define PCM_PIN_TX 6
`define PCM_PIN_RX 7

`endif

/* File: src/pcm_pkg.sv */
/*
 * Types of the port C pin mux.
 * Assumes pcm_regs.svh on the include path.
 */
`include "pcm_regs.svh"

package pcm_pkg;

    // ==========================================
    // pin bundles
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pcm_pin_drive_t;

    // sync serial peripheral side
    typedef struct packed {
        logic sck_out;
        logic sdo;
        logic sda_out;
        logic sda_oe;
        logic scl_out;
        logic scl_oe;
        logic spi_master;
    } pcm_ssp_out_t;

    typedef struct packed {
        logic sck_in;
        logic sdi;
        logic scl_in;
        logic sda_in;
    } pcm_ssp_in_t;

    // enhanced serial peripheral side
    typedef struct packed {
        logic tx;
        logic ck_out;
        logic dt_out;
    } pcm_usart_out_t;

    typedef struct packed {
        logic ck_in;
        logic rx;
        logic dt_in;
    } pcm_usart_in_t;

    // capture/compare channel two
    typedef struct packed {
        logic out;
        logic out_en;
    } pcm_ccp_out_t;

    typedef enum logic [1:0] {
        PCM_SRC_PORT,
        PCM_SRC_SYNC,
        PCM_SRC_USART
    } pcm_src_t;

endpackage : pcm_pkg

/* File: src/pcm_pin_sync.sv */
/*
 * Two-stage synchroniser for the eight pin levels.
 * Assumes asynchronous pin inputs and one system clock.
 */
module pcm_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } pcm_sync_state_t;

    pcm_sync_state_t state_q;
    pcm_sync_state_t state_d;

    // ==========================================
    // stage chain
    always_comb begin
        state_d.s1 = i_async;
        state_d.s2 = state_q.s1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_sync = state_q.s2;

endmodule : pcm_pin_sync

/* File: src/pcm_input_buf.sv */
/*
 * Input qualifier per pin: schmitt or i2c/smbus threshold stand-in.
 * Assumes already synchronised levels; smbus uses a two-sample filter.
 */
module pcm_input_buf #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_level,
    input wire logic [WIDTH-1:0] i_smbus,
    output logic [WIDTH-1:0] o_level
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] held;
    } pcm_buf_state_t;

    pcm_buf_state_t state_q;
    pcm_buf_state_t state_d;

    // ==========================================
    // hysteresis: smbus pins change only on two equal samples, other pins follow each sample
    always_comb begin
        state_d.prev = i_level;
        state_d.held = state_q.held;
        for (int i = 0; i < WIDTH; i++) begin
            if (!i_smbus[i] || (i_level[i] == state_q.prev[i])) begin
                state_d.held[i] = i_level[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_level = state_q.held;

endmodule : pcm_input_buf

/* File: test/pcm_port_c_mux_properties.sv */
/* Checker for the port C pin mux: pin drive against mode and registers.
   Assumes binding to pcm_port_c_mux and control bits as in the package. */
module pcm_port_c_mux_properties #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [WIDTH-1:0] i_pin,
    input wire logic [WIDTH-1:0] o_pin,
    input wire logic [WIDTH-1:0] o_pin_oe,
    input wire logic i_ccp_two_pin_select,
    input wire pcm_pkg::pcm_ssp_out_t i_ssp,
    input wire pcm_pkg::pcm_ssp_in_t o_ssp,
    input wire pcm_pkg::pcm_usart_out_t i_usart,
    input wire pcm_pkg::pcm_usart_in_t o_usart,
    input wire pcm_pkg::pcm_ccp_out_t i_ccp,
    input wire logic o_ccp_in,
    input wire logic o_ccp_alt_out,
    input wire logic o_ccp_alt_oe
);
    // ==========
    // shadow registers
    logic [7:0] dir_q, lat_q, ctl_q, rexp;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_q <= 8'hFF;
            lat_q <= 8'h00;
            ctl_q <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == 2'h2) dir_q <= i_wdata;
            if (i_addr[1] == 1'h0) lat_q <= i_wdata;
            if (i_addr == 2'h3) ctl_q <= i_wdata;
        end
    end
    always_comb rexp = i_addr[0] ? lat_q : dir_q;
    wire spi = ctl_q[0] & ~ctl_q[1];
    wire i2c = ctl_q[0] & ctl_q[1];
    wire uas = ctl_q[3] & ~ctl_q[4];
    wire usy = ctl_q[3] & ctl_q[4];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // checks
    AST_RST_IN: assert property (!$past(i_rst_n) |-> o_pin_oe == '0)
        else $error("pin driven after reset");
    AST_PLAIN: assert property (ctl_q == 8'h00 |->
        o_pin_oe[7:3] == ~dir_q[7:3] &&
        (o_pin[7:3] | dir_q[7:3]) == (lat_q[7:3] | dir_q[7:3]))
        else $error("plain pin drive wrong");
    AST_RD: assert property ($past(i_rd) && $past(i_addr) inside {2'h1, 2'h2}
        |-> o_rdata == $past(rexp))
        else $error("register read wrong");
    AST_SCK: assert property (spi && i_ssp.spi_master && !dir_q[3]
        |-> o_pin_oe[3] && o_pin[3] == i_ssp.sck_out)
        else $error("spi clock not driven");
    AST_SDO: assert property (spi |-> !o_pin_oe[4] &&
        o_pin_oe[5] == !dir_q[5] && (dir_q[5] || o_pin[5] == i_ssp.sdo))
        else $error("spi data pins wrong");
    AST_I2C: assert property (i2c |->
        o_pin_oe[4:3] == {i_ssp.sda_oe, i_ssp.scl_oe} &&
        (!i_ssp.sda_oe || o_pin[4] == i_ssp.sda_out))
        else $error("i2c pins wrong");
    AST_TX: assert property (uas |-> o_pin_oe[6] && o_pin[6] == i_usart.tx)
        else $error("transmit pin wrong");
    AST_CK: assert property (usy && ctl_q[5] |->
        o_pin_oe[6] && o_pin[6] == i_usart.ck_out)
        else $error("sync clock pin wrong");
    AST_DT: assert property (usy && ctl_q[6] |->
        o_pin_oe[7] && o_pin[7] == i_usart.dt_out)
        else $error("sync data pin wrong");
    AST_CCP: assert property (i_ccp_two_pin_select && i_ccp.out_en &&
        !dir_q[1] |-> o_pin_oe[1] && o_pin[1] == i_ccp.out && !o_ccp_alt_oe)
        else $error("channel two pin wrong");
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
endmodule : pcm_port_c_mux_properties

bind pcm_port_c_mux pcm_port_c_mux_properties #(.WIDTH(WIDTH)) u_props (.*);

/* File: test/pcm_board.sv */
/* Board model: resolves each pin from chip and board drivers.
   Assumes board pull-ups on every pin of the port. */
module pcm_board (
    input wire logic [7:0] i_drv,
    input wire logic [7:0] i_drv_oe,
    input wire logic [7:0] i_ext,
    input wire logic [7:0] i_ext_en,
    output logic [7:0] o_level
);
    // chip drive first, then board, else pull-up
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            o_level[b] = i_drv_oe[b] ? i_drv[b] : (i_ext_en[b] ? i_ext[b] : 1'h1);
        end
    end
endmodule : pcm_board

/* File: test/pcm_port_c_mux_tb.sv */
/* Testbench of the port C pin mux: registers and peripheral modes.
   Assumes the board model and the checker bound to the design. */
module pcm_port_c_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic sel = 1'h1;
    logic [7:0] ext = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] rdata, pin_in, pin, pin_oe;
    logic ccp_in, alt_out, alt_oe;
    pcm_pkg::pcm_ssp_out_t ssp = '0;
    pcm_pkg::pcm_ssp_in_t ssp_in;
    pcm_pkg::pcm_usart_out_t ua = '0;
    pcm_pkg::pcm_usart_in_t ua_in;
    pcm_pkg::pcm_ccp_out_t ccp = '0;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    pcm_port_c_mux u_pcm_port_c_mux (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_pin(pin_in), .o_pin(pin), .o_pin_oe(pin_oe),
        .i_ccp_two_pin_select(sel), .i_ssp(ssp), .o_ssp(ssp_in),
        .i_usart(ua), .o_usart(ua_in), .i_ccp(ccp), .o_ccp_in(ccp_in),
        .o_ccp_alt_out(alt_out), .o_ccp_alt_oe(alt_oe));
    pcm_board u_pcm_board (.i_drv(pin), .i_drv_oe(pin_oe), .i_ext(ext),
        .i_ext_en(ext_en), .o_level(pin_in));

    initial begin
        forever #5 clk = ~clk;
    end

    // ==========
    // tasks
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end

    // ==========
    // sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(2'h2, 8'hFF);
        chk(pin_oe, 8'h00);
        wr_reg(2'h1, 8'hA5);
        rd_reg(2'h1, 8'hA5);
        wr_reg(2'h0, 8'h3C);
        rd_reg(2'h1, 8'h3C);
        @(posedge clk);
        ext <= 8'hDA;
        ext_en <= 8'hFF;
        tick(5);
        rd_reg(2'h0, 8'hDA);
        wr_reg(2'h2, 8'h00);
        rd_reg(2'h2, 8'h00);
        chk(pin_oe, 8'hFF);
        chk(pin, 8'h3C);
        ssp <= '{sck_out: 1'h1, spi_master: 1'h1, default: 1'h0};
        wr_reg(2'h3, 8'h01);
        tick(1);
        chk({3'h0, pin_oe[5:3], pin[5], pin[3]}, 8'h15);
        wr_reg(2'h2, 8'hFF);
        tick(5);
        chk({6'h00, ssp_in.sck_in, ssp_in.sdi}, 8'h03);
        chk(pin_oe, 8'h00);
        ssp <= '{sda_oe: 1'h1, default: 1'h0};
        wr_reg(2'h3, 8'h07);
        tick(6);
        chk({3'h0, pin_oe[4], pin[4], pin_oe[3], ssp_in.scl_in,
            ssp_in.sda_in}, 8'h12);
        wr_reg(2'h3, 8'h03);
        tick(5);
        chk({6'h00, ssp_in.scl_in, ssp_in.sda_in}, 8'h02);
        ua <= '{tx: 1'h1, default: 1'h0};
        wr_reg(2'h3, 8'h08);
        tick(5);
        chk({5'h00, pin_oe[6], pin[6], ua_in.rx}, 8'h07);
        rd_reg(2'h2, 8'hFF);
        tick(1);
        chk(rdata, 8'h00);
        ua <= '{ck_out: 1'h1, dt_out: 1'h1, default: 1'h0};
        wr_reg(2'h3, 8'h78);
        tick(1);
        chk({4'h0, pin_oe[7:6], pin[7:6]}, 8'h0F);
        wr_reg(2'h3, 8'h18);
        tick(5);
        chk({5'h00, pin_oe[6], ua_in.ck_in, ua_in.dt_in}, 8'h03);
        ccp <= '{out: 1'h1, out_en: 1'h1};
        wr_reg(2'h3, 8'h00);
        wr_reg(2'h2, 8'hFD);
        tick(1);
        chk({5'h00, pin_oe[1], pin[1], alt_oe}, 8'h06);
        sel <= 1'h0;
        tick(1);
        chk({4'h0, pin_oe[1], pin[1], alt_oe, alt_out}, 8'h0B);
        close_out();
    end
endmodule : pcm_port_c_mux_tb
